//--- mlal_defs.svh
`ifndef MLAL_DEFS_SVH
`define MLAL_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MLAL_OFS_CFG 8'h00
`define MLAL_OFS_STAT 8'h01
`define MLAL_OFS_MASK 8'h03
`define MLAL_OFS_RATE 8'h07
`define MLAL_OFS_CHDIS 8'h08
`define MLAL_OFS_ONESHOT 8'h09
`define MLAL_OFS_ADVCFG 8'h0b
`define MLAL_OFS_LIM_LO 8'h2a
`define MLAL_OFS_LIM_HI 8'h39
`define MLAL_OFS_THOT 8'h38
`define MLAL_OFS_THYST 8'h39

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define MLAL_CFG_START 0
`define MLAL_CFG_INTEN 1
`define MLAL_CFG_INTCLR 3
`define MLAL_CFG_INIT 7
`define MLAL_CFG_RST 8'h08
`define MLAL_ZERO_RST 8'h00
`define MLAL_RATE_CONT 0
`define MLAL_ADV_MODE_LSB 1
`define MLAL_MODE_ALLV 2'h1
`define MLAL_MODE_DIFF 2'h2
`define MLAL_MODE_MIX 2'h3
`define MLAL_MODE_DIFF_CHS 3'h4
`define MLAL_MODE_MIX_CHS 3'h6
`define MLAL_TEMP_CH 3'h7
`define MLAL_LAST_CH 3'h7
`define MLAL_FIRST_CH 3'h0
`define MLAL_TEMP_BITS 9
`define MLAL_VOLT_TOP 11
`define MLAL_VOLT_LSB 4

// ----------------------------------------
// timing
// ----------------------------------------
`define MLAL_LP_CYCLE_MS 728
`define MLAL_CLK_MHZ 250
`define MLAL_LP_CYCLES (`MLAL_LP_CYCLE_MS * `MLAL_CLK_MHZ * 1000)

`endif

//--- mlal_pkg.sv
`include "mlal_defs.svh"

package mlal_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mlal_req_t;

    typedef struct packed {
        logic valid;
        logic [2:0] chan;
        logic [11:0] data;
    } mlal_conv_t;

    typedef enum logic [1:0] {CMP_IDLE, CMP_RDHI, CMP_RDLO} mlal_cmp_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_NEXT, SEQ_WAIT, SEQ_END} mlal_seq_t;

    function automatic logic mlal_present(input logic [1:0] m, input logic [2:0] c);
        logic ok;
        ok = 1'b1;
        if (m == `MLAL_MODE_DIFF) begin
            ok = c < `MLAL_MODE_DIFF_CHS;
        end else if (m == `MLAL_MODE_MIX) begin
            ok = c < `MLAL_MODE_MIX_CHS;
        end
        return ok || (c == `MLAL_TEMP_CH);
    endfunction : mlal_present

    function automatic logic mlal_is_temp(input logic [1:0] m, input logic [2:0] c);
        return (m != `MLAL_MODE_ALLV) && (c == `MLAL_TEMP_CH);
    endfunction : mlal_is_temp

endpackage : mlal_pkg

//--- mlal_limit_mem.sv
`timescale 1ns/1ps

module mlal_limit_mem import mlal_pkg::*; #(
    parameter int W = 8,
    parameter int D = 16,
    parameter int AW = $clog2(D)
) (
    input wire logic clock,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [W-1:0] wrData,
    input wire logic [AW-1:0] rdAddrA,
    output logic [W-1:0] rdDataA,
    input wire logic [AW-1:0] rdAddrB,
    output logic [W-1:0] rdDataB
);
    // limits power up indeterminate, so no reset on the array
    logic [W-1:0] mem [D];

    always_ff @(posedge clock) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdDataA <= mem[rdAddrA];
        rdDataB <= mem[rdAddrB];
    end

endmodule : mlal_limit_mem

//--- mlal_seq.sv
`timescale 1ns/1ps
`include "mlal_defs.svh"

module mlal_seq import mlal_pkg::*; #(
    parameter int LP_CYCLES = `MLAL_LP_CYCLES,
    parameter int CW = $clog2(LP_CYCLES + 1)
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic run,
    input wire logic halt,
    input wire logic lowPower,
    input wire logic oneShot,
    input wire logic [1:0] mode,
    input wire logic [7:0] chanDis,
    input wire logic convDone,
    output logic convStart_r,
    output logic [2:0] chan_r,
    output logic busy_r
);
    mlal_seq_t state_r;
    logic pass1_r;
    logic [CW-1:0] cyc_r;

    wire chanOn = mlal_present(mode, chan_r) && !chanDis[chan_r];
    wire lastChan = chan_r == `MLAL_LAST_CH;
    wire lpDone = cyc_r >= CW'(LP_CYCLES - 1);
    wire go = (run || oneShot) && !halt;
    wire keepOn = run || pass1_r;

    // ----------------------------------------
    // round-robin walk
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_r <= SEQ_IDLE;
            chan_r <= `MLAL_FIRST_CH;
            pass1_r <= 1'b0;
            cyc_r <= '0;
            convStart_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            convStart_r <= 1'b0;
            cyc_r <= cyc_r + 1'b1;
            busy_r <= state_r != SEQ_IDLE;
            unique case (state_r)
                SEQ_IDLE: begin
                    if (go) begin
                        chan_r <= `MLAL_FIRST_CH;
                        pass1_r <= !run;
                        cyc_r <= '0;
                        state_r <= SEQ_NEXT;
                    end
                end
                SEQ_NEXT: begin
                    if (halt || !keepOn) begin
                        state_r <= SEQ_IDLE;
                    end else if (chanOn) begin
                        convStart_r <= 1'b1;
                        state_r <= SEQ_WAIT;
                    end else if (lastChan) begin
                        state_r <= SEQ_END;
                    end else begin
                        chan_r <= chan_r + 1'b1;
                    end
                end
                SEQ_WAIT: begin
                    // a started conversion always finishes
                    if (convDone) begin
                        if (lastChan) begin
                            state_r <= SEQ_END;
                        end else begin
                            chan_r <= chan_r + 1'b1;
                            state_r <= SEQ_NEXT;
                        end
                    end
                end
                SEQ_END: begin
                    // low power idles here until the period is used up
                    if (pass1_r || halt || !run) begin
                        pass1_r <= 1'b0;
                        state_r <= SEQ_IDLE;
                    end else if (!lowPower || lpDone) begin
                        chan_r <= `MLAL_FIRST_CH;
                        cyc_r <= '0;
                        state_r <= SEQ_NEXT;
                    end
                end
            endcase
        end
    end

endmodule : mlal_seq

//--- mlal_top.sv
`timescale 1ns/1ps
`include "mlal_defs.svh"

// Contract
// - a temperature reading is 9-bit two's complement, half a degree per step.
// - a temperature limit is 8-bit two's complement, one degree per step.
// - temperature above the high limit at 38h raises its interrupt; 39h holds hysteresis.
// - alert is active only with clear low, enable high and a live violation.
// - reading the status register returns it and then clears every bit not set by a violation in that cycle.
// - clearing the status releases alert until the loop sets a new violation.
// - writing the clear control bit high releases the alert.
// - while the clear control bit is high the monitoring loop is stopped.
// - a temperature interrupt holds until a status read or the initialization bit.
// - after reset of a high-limit interrupt it comes back at the next conversion.
// - it keeps coming back until reading is at or below hysteresis and status was read.
// - conversion runs continuous, low power, or one pass on demand.
// - low power converts all enabled channels once then sleeps, about 728 ms a cycle.
// - channel set per mode: 1+7, 0+8, 1+4, 1+6 temperature plus voltage.
// - a mask bit of one keeps its status bit off the alert output.
module mlal_top import mlal_pkg::*; #(
    parameter int LP_CYCLES = `MLAL_LP_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire mlal_req_t req,
    output logic [7:0] rdData,
    output logic rdValid,
    input wire mlal_conv_t conv,
    output logic convStart,
    output logic [2:0] convChan,
    output logic busy,
    output logic alertN
);
    logic [7:0] cfg_r;
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [7:0] mask_r;
    logic [7:0] rate_r;
    logic [7:0] chDis_r;
    logic [7:0] advCfg_r;
    logic [7:0] rdRegVal_r;
    logic rdIsLim_r;
    logic rdPend_r;
    logic [7:0] rdData_r;
    logic rdValid_r;
    logic alertN_r;
    mlal_cmp_t cmp_r;
    logic [2:0] chanL_r;
    logic [11:0] dataL_r;
    logic [7:0] hi_r;
    logic hotLatch_r;
    logic [7:0] memA;
    logic [7:0] memB;

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    wire wrCfg = req.wr && req.addr == `MLAL_OFS_CFG;
    wire wrMask = req.wr && req.addr == `MLAL_OFS_MASK;
    wire wrRate = req.wr && req.addr == `MLAL_OFS_RATE;
    wire wrChDis = req.wr && req.addr == `MLAL_OFS_CHDIS;
    wire wrOneShot = req.wr && req.addr == `MLAL_OFS_ONESHOT;
    wire wrAdv = req.wr && req.addr == `MLAL_OFS_ADVCFG;
    wire inLim = req.addr >= `MLAL_OFS_LIM_LO && req.addr <= `MLAL_OFS_LIM_HI;
    wire limWr = req.wr && inLim;
    wire [3:0] limIdx = 4'(req.addr - `MLAL_OFS_LIM_LO);
    wire statusRead = req.rd && req.addr == `MLAL_OFS_STAT;
    wire initReq = wrCfg && req.wdata[`MLAL_CFG_INIT];
    wire clrBit = cfg_r[`MLAL_CFG_INTCLR];
    wire [1:0] mode = advCfg_r[`MLAL_ADV_MODE_LSB +: 2];
    wire [7:0] regVal =
        req.addr == `MLAL_OFS_CFG ? cfg_r :
        req.addr == `MLAL_OFS_STAT ? status_r :
        req.addr == `MLAL_OFS_MASK ? mask_r :
        req.addr == `MLAL_OFS_RATE ? rate_r :
        req.addr == `MLAL_OFS_CHDIS ? chDis_r :
        req.addr == `MLAL_OFS_ADVCFG ? advCfg_r : `MLAL_ZERO_RST;

    // ----------------------------------------
    // limit store and loop
    // ----------------------------------------
    wire [3:0] cmpIdx = cmp_r == CMP_IDLE ? {conv.chan, 1'b0} : {chanL_r, 1'b1};

    mlal_limit_mem #(
        .W(8),
        .D(16)
    ) u_limits (
        .clock(clock),
        .wrEn(limWr),
        .wrAddr(limIdx),
        .wrData(req.wdata),
        .rdAddrA(limIdx),
        .rdDataA(memA),
        .rdAddrB(cmpIdx),
        .rdDataB(memB)
    );

    mlal_seq #(
        .LP_CYCLES(LP_CYCLES)
    ) u_seq (
        .clock(clock),
        .reset_n(reset_n),
        .run(cfg_r[`MLAL_CFG_START]),
        .halt(clrBit),
        .lowPower(!rate_r[`MLAL_RATE_CONT]),
        .oneShot(wrOneShot),
        .mode(mode),
        .chanDis(chDis_r),
        .convDone(conv.valid),
        .convStart_r(convStart),
        .chan_r(convChan),
        .busy_r(busy)
    );

    // ----------------------------------------
    // limit compare
    // ----------------------------------------
    // both sides widened to 10-bit half-degree units so sign survives
    wire evalNow = cmp_r == CMP_RDLO;
    wire isTemp = mlal_is_temp(mode, chanL_r);
    wire [9:0] tExt = {dataL_r[`MLAL_TEMP_BITS-1], dataL_r[`MLAL_TEMP_BITS-1:0]};
    wire [9:0] hotExt = {hi_r[7], hi_r, 1'b0};
    wire [9:0] hystExt = {memB[7], memB, 1'b0};
    wire overHot = $signed(tExt) > $signed(hotExt);
    wire belowHyst = $signed(tExt) <= $signed(hystExt);
    wire [7:0] vTop = dataL_r[`MLAL_VOLT_TOP:`MLAL_VOLT_LSB];
    wire voltViol = vTop > hi_r || vTop <= memB;
    wire tempViol = overHot || (hotLatch_r && !belowHyst);
    wire viol = isTemp ? tempViol : voltViol;
    wire [7:0] statSet = (evalNow && viol) ? 8'(8'h01 << chanL_r) : 8'h00;
    wire alertLive = !clrBit && cfg_r[`MLAL_CFG_INTEN] && |(status_r & ~mask_r);

    // set wins over the read clear so no event is lost
    always_comb begin
        status_nxt = (statusRead || initReq) ? 8'h00 : status_r;
        status_nxt = status_nxt | statSet;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cmp_r <= CMP_IDLE;
            chanL_r <= `MLAL_FIRST_CH;
            dataL_r <= '0;
            hi_r <= `MLAL_ZERO_RST;
            hotLatch_r <= 1'b0;
        end else begin
            unique case (cmp_r)
                CMP_IDLE: begin
                    // results during a compare are dropped; loop waits anyway
                    if (conv.valid) begin
                        chanL_r <= conv.chan;
                        dataL_r <= conv.data;
                        cmp_r <= CMP_RDHI;
                    end
                end
                CMP_RDHI: begin
                    hi_r <= memB;
                    cmp_r <= CMP_RDLO;
                end
                CMP_RDLO: begin
                    cmp_r <= CMP_IDLE;
                    if (isTemp && overHot) begin
                        hotLatch_r <= 1'b1;
                    end else if (isTemp && belowHyst) begin
                        hotLatch_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // registers and read path
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!reset_n || initReq) begin
            cfg_r <= `MLAL_CFG_RST;
            mask_r <= `MLAL_ZERO_RST;
            rate_r <= `MLAL_ZERO_RST;
            chDis_r <= `MLAL_ZERO_RST;
            advCfg_r <= `MLAL_ZERO_RST;
        end else begin
            if (wrCfg) begin
                cfg_r <= req.wdata & ~(8'h01 << `MLAL_CFG_INIT);
            end
            if (wrMask) begin
                mask_r <= req.wdata;
            end
            if (wrRate) begin
                rate_r <= req.wdata;
            end
            if (wrChDis) begin
                chDis_r <= req.wdata;
            end
            if (wrAdv) begin
                advCfg_r <= req.wdata;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            status_r <= `MLAL_ZERO_RST;
            rdRegVal_r <= `MLAL_ZERO_RST;
            rdIsLim_r <= 1'b0;
            rdPend_r <= 1'b0;
            rdData_r <= `MLAL_ZERO_RST;
            rdValid_r <= 1'b0;
            alertN_r <= 1'b1;
        end else begin
            status_r <= status_nxt;
            rdRegVal_r <= regVal;
            rdIsLim_r <= inLim;
            rdPend_r <= req.rd;
            rdData_r <= rdIsLim_r ? memA : rdRegVal_r;
            rdValid_r <= rdPend_r;
            alertN_r <= !alertLive;
        end
    end

    assign rdData = rdData_r;
    assign rdValid = rdValid_r;
    assign alertN = alertN_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_alert_clear_gate: assert property (clrBit |=> alertN)
        else $error("alert active while clear bit set");

    a_alert_mask_off: assert property ((status_r & ~mask_r) == 8'h00 |=> alertN)
        else $error("masked status drove alert");

    a_alert_asserts: assert property (alertLive |=> !alertN)
        else $error("alert not driven on live violation");

    a_alert_needs_en: assert property (!cfg_r[`MLAL_CFG_INTEN] |=> alertN)
        else $error("alert active while output disabled");

    // a read with no fresh violation behind it must release the pin
    a_alert_release: assert property (statusRead && statSet == 8'h00
        ##1 statSet == 8'h00 |=> alertN)
        else $error("alert held after status cleared");

    a_status_rd_clr: assert property (statusRead && statSet == 8'h00 && !initReq
        |=> status_r == 8'h00)
        else $error("status not cleared by read");

    a_status_set_wins: assert property (statSet != 8'h00
        |=> (status_r & $past(statSet)) == $past(statSet))
        else $error("violation lost from status");

    a_read_returns: assert property (statusRead
        |-> ##2 rdValid && rdData == $past(status_r, 2))
        else $error("status read returned wrong value");

    a_rd_valid_lag: assert property (req.rd |-> ##2 rdValid)
        else $error("read answer missing");

    a_rd_no_spur: assert property (!req.rd |-> ##2 !rdValid)
        else $error("read answer without request");

    a_temp_hot_set: assert property (evalNow && isTemp && overHot
        |=> status_r[`MLAL_TEMP_CH])
        else $error("hot temperature not flagged");

    // guards against a flag raised by a cool reading
    a_temp_quiet: assert property (evalNow && isTemp && !overHot && !hotLatch_r
        && !statusRead && !initReq
        |=> status_r[`MLAL_TEMP_CH] == $past(status_r[`MLAL_TEMP_CH]))
        else $error("temperature flagged without violation");

    a_temp_latch_set: assert property (evalNow && isTemp && overHot |=> hotLatch_r)
        else $error("hot latch not set");

    a_temp_latch_clr: assert property (evalNow && isTemp && !overHot && belowHyst
        |=> !hotLatch_r)
        else $error("hot latch not released below hysteresis");

    a_temp_repeat: assert property (evalNow && isTemp && hotLatch_r && !belowHyst
        |=> status_r[`MLAL_TEMP_CH])
        else $error("temperature interrupt not repeated");

    a_volt_flag: assert property (evalNow && !isTemp && voltViol
        |=> status_r[chanL_r])
        else $error("voltage violation not flagged");

    a_status_hold: assert property (!statusRead && !initReq && status_r[`MLAL_TEMP_CH]
        |=> status_r[`MLAL_TEMP_CH])
        else $error("temperature status dropped without read");

    a_halt_loop: assert property (clrBit [*2] |=> !convStart)
        else $error("conversion started while halted");

    a_start_chan_on: assert property (convStart
        |-> mlal_present($past(mode), convChan) && $past(chDis_r[convChan]) == 1'b0)
        else $error("conversion started on absent channel");

    a_busy_start: assert property (convStart |-> busy)
        else $error("conversion started while idle");

endmodule : mlal_top

//--- mlal_conv_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// datapath stand-in: answers each start after a chosen lag
// ----------------------------------------
module mlal_conv_model import mlal_pkg::*; (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic convStart,
    input wire logic [2:0] convChan,
    input wire logic [11:0] dataIn,
    input wire logic [2:0] lag,
    output mlal_conv_t conv
);
    logic pend_r;
    logic [2:0] cnt_r;
    logic [2:0] chan_r;

    // idle fields toggle so a stale result can never look valid
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pend_r <= 1'b0;
            cnt_r <= 3'h0;
            chan_r <= 3'h0;
            conv <= '0;
        end else begin
            conv.valid <= 1'b0;
            conv.chan <= ~conv.chan;
            conv.data <= ~conv.data;
            if (convStart) begin
                pend_r <= 1'b1;
                cnt_r <= lag;
                chan_r <= convChan;
            end else if (pend_r && cnt_r != 3'h0) begin
                cnt_r <= cnt_r - 3'h1;
            end else if (pend_r) begin
                pend_r <= 1'b0;
                conv <= '{valid: 1'b1, chan: chan_r, data: dataIn};
            end
        end
    end
endmodule : mlal_conv_model

//--- test_monitor_limit_alert_logic.sv
`timescale 1ns/1ps
`include "mlal_defs.svh"

module test_monitor_limit_alert_logic import mlal_pkg::*; ();
    localparam int LPC = 64;
    logic clock, reset_n, rdValid, convStart, busy, alertN;
    mlal_req_t req;
    mlal_conv_t conv;
    logic [7:0] rdData, d, seenCh, lim;
    logic [2:0] convChan, lag;
    logic [11:0] dataIn;
    logic [31:0] v;
    int seed, miscompares, checks, cyc, starts, lastStart, gap, i, s;
    logic [8:0] cr [6] = '{9'h1ff, 9'h1fe, 9'h033, 9'h032, 9'h000, 9'h001};
    logic [7:0] cl [6] = '{8'hff, 8'hff, 8'h19, 8'h19, 8'h00, 8'h00};
    logic [8:0] hr [4] = '{9'h034, 9'h02c, 9'h028, 9'h02c};
    logic [7:0] he [4] = '{8'h80, 8'h80, 8'h00, 8'h00};

    mlal_top #(.LP_CYCLES(LPC)) mlal_top_i (.clock(clock), .reset_n(reset_n), .req(req),
        .rdData(rdData), .rdValid(rdValid), .conv(conv), .convStart(convStart),
        .convChan(convChan), .busy(busy), .alertN(alertN));
    mlal_conv_model mlal_conv_model_i (.clock(clock), .reset_n(reset_n), .convStart(convStart),
        .convChan(convChan), .dataIn(dataIn), .lag(lag), .conv(conv));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    always @(posedge clock) begin
        cyc++;
        if (convStart === 1'b1) begin
            seenCh[convChan] = 1'b1;
            starts++;
            gap = cyc - lastStart;
            lastStart = cyc;
        end
    end

    function automatic logic tempViol(input logic [8:0] t, input logic [7:0] lim);
        return $signed({t[8], t}) > $signed({lim, 1'b0});
    endfunction : tempViol

    function automatic logic [7:0] expChans(input int m);
        return (m == 2) ? 8'h8f : (m == 3) ? 8'hbf : 8'hff;
    endfunction : expChans

    task automatic close_out();
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic hang();
        miscompares++;
        close_out();
    endtask : hang

    task automatic wrReg(input logic [7:0] a, input logic [7:0] w);
        @(negedge clock);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = w;
        @(negedge clock);
        req.wr = 1'b0;
    endtask : wrReg

    // answer lands one edge after the taking edge
    task automatic rdReg(input logic [7:0] a, output logic [7:0] q);
        int k;
        @(negedge clock);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clock);
        req.rd = 1'b0;
        for (k = 0; k < 5 && rdValid !== 1'b1; k++) @(negedge clock);
        if (rdValid !== 1'b1) hang();
        q = rdData;
    endtask : rdReg

    task automatic oneShot(input logic [8:0] t);
        int k, n;
        dataIn = {3'h0, t};
        lag = 3'($random(seed));
        n = starts;
        wrReg(`MLAL_OFS_ONESHOT, 8'h01);
        for (k = 0; k < 20 && starts == n; k++) @(negedge clock);
        if (starts == n) hang();
        for (k = 0; k < 300 && busy !== 1'b0; k++) @(negedge clock);
        if (busy !== 1'b0) hang();
        repeat (6) @(negedge clock);
    endtask : oneShot

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = 61;
        req = '0;
        dataIn = 12'h000;
        lag = 3'h0;
        reset_n = 1'b0;
        seenCh = 8'h00;
        repeat (6) @(negedge clock);
        reset_n = 1'b1;
        chk(alertN, 1'b1);
        chk(busy, 1'b0);
        foreach (cr[j]) begin
            v = {24'h0, (j == 0) ? 8'h00 : (j == 1) ? 8'h01 : (j == 2) ? 8'h03 : (j == 3) ?
                8'h09 : (j == 4) ? 8'h0b : 8'h3c};
            rdReg(v[7:0], d);
            chk(d, (j == 0) ? 8'h08 : 8'h00);
        end
        wrReg(`MLAL_OFS_CFG, 8'h83);
        rdReg(`MLAL_OFS_CFG, d);
        chk(d, 8'h08);
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            wrReg(`MLAL_OFS_THOT, v[7:0]);
            wrReg(`MLAL_OFS_THYST, v[15:8]);
            rdReg(`MLAL_OFS_THOT, d);
            chk(d, v[7:0]);
            rdReg(`MLAL_OFS_THYST, d);
            chk(d, v[15:8]);
        end
        wrReg(`MLAL_OFS_STAT, 8'hff);
        rdReg(`MLAL_OFS_STAT, d);
        chk(d, 8'h00);
        // only the temperature channel, hysteresis out of the way
        wrReg(`MLAL_OFS_CHDIS, 8'h7f);
        wrReg(`MLAL_OFS_THYST, 8'h7f);
        wrReg(`MLAL_OFS_CFG, 8'h02);
        for (i = 0; i < 16; i++) begin
            v = $random(seed);
            lim = (i < 6) ? cl[i] : v[7:0];
            v[8:0] = (i < 6) ? cr[i] : (v[16:8] == 9'h0ff) ? 9'h0fe : v[16:8];
            wrReg(`MLAL_OFS_THOT, lim);
            oneShot(v[8:0]);
            chk(alertN, !tempViol(v[8:0], lim));
            rdReg(`MLAL_OFS_STAT, d);
            chk(d, {tempViol(v[8:0], lim), 7'h00});
            chk(d[7], tempViol(v[8:0], lim));
        end
        wrReg(`MLAL_OFS_THOT, 8'h19);
        wrReg(`MLAL_OFS_THYST, 8'h14);
        for (i = 0; i < 4; i++) begin
            oneShot(hr[i]);
            rdReg(`MLAL_OFS_STAT, d);
            chk(d, he[i]);
        end
        oneShot(9'h034);
        repeat (30) @(negedge clock);
        chk(alertN, 1'b0);
        rdReg(`MLAL_OFS_STAT, d);
        chk(alertN, 1'b1);
        oneShot(9'h02c);
        wrReg(`MLAL_OFS_CFG, 8'h0a);
        repeat (2) @(negedge clock);
        chk(alertN, 1'b1);
        rdReg(`MLAL_OFS_STAT, d);
        chk(d, 8'h80);
        wrReg(`MLAL_OFS_CFG, 8'h02);
        wrReg(`MLAL_OFS_MASK, 8'h80);
        oneShot(9'h034);
        chk(alertN, 1'b1);
        rdReg(`MLAL_OFS_STAT, d);
        chk(d, 8'h80);
        wrReg(`MLAL_OFS_MASK, 8'h00);
        wrReg(`MLAL_OFS_CFG, 8'h00);
        oneShot(9'h034);
        chk(alertN, 1'b1);
        wrReg(`MLAL_OFS_RATE, 8'h01);
        wrReg(`MLAL_OFS_CFG, 8'h0b);
        s = starts;
        repeat (40) @(negedge clock);
        chk(starts - s, 0);
        wrReg(`MLAL_OFS_CFG, 8'h03);
        repeat (80) @(negedge clock);
        chk(starts > s + 2, 1'b1);
        wrReg(`MLAL_OFS_RATE, 8'h00);
        s = starts;
        for (i = 0; i < 400 && starts < s + 4; i++) @(negedge clock);
        if (starts < s + 4) hang();
        chk(gap, LPC);
        wrReg(`MLAL_OFS_CFG, 8'h02);
        wrReg(`MLAL_OFS_CHDIS, 8'h00);
        for (i = 8'h2a; i < 8'h38; i++) wrReg(i[7:0], 8'hff);
        for (i = 0; i < 4; i++) begin
            wrReg(`MLAL_OFS_ADVCFG, {5'h00, i[1:0], 1'b0});
            repeat (10) @(negedge clock);
            rdReg(`MLAL_OFS_STAT, d);
            seenCh = 8'h00;
            oneShot(9'h000);
            chk(seenCh, expChans(i));
            rdReg(`MLAL_OFS_STAT, d);
            chk(d, (i == 1) ? 8'hff : expChans(i) & 8'h7f);
        end
        close_out();
    end
endmodule : test_monitor_limit_alert_logic
